// ==== dv/sir_init_model.sv ====
// Initiator model: sends six-byte command blocks and sinks the answer.
// Assumes the same clock as the responder; tasks are called from the bench.
`timescale 1ns/10ps
`default_nettype none
module sir_init_model (
    input wire logic clk,
    input wire logic slow,
    output logic cdb_valid,
    output logic [7:0] cdb_byte,
    input wire logic cdb_ready,
    input wire logic [7:0] dout,
    input wire logic dout_valid,
    output logic dout_ready
);
    logic [7:0] got [0:63];
    logic [1:0] ph_r;
    int n_got;
    initial begin
        cdb_valid = 1'b0;
        cdb_byte = 8'h00;
        dout_ready = 1'b0;
        ph_r = 2'h0;
        n_got = 0;
    end
    // Slow mode stalls three cycles in four to exercise the hold.
    always @(posedge clk) begin
        ph_r <= ph_r + 2'h1;
        dout_ready <= !slow || ph_r == 2'h3;
        if (dout_valid && dout_ready) begin
            got[n_got[5:0]] <= dout;
            n_got <= n_got + 1;
        end
    end
    task automatic clear();
        n_got = 0;
    endtask
    // The released line shows the inverse, so a stale byte never passes.
    task automatic send_cdb(input logic [7:0] op, rsv, len);
        logic [7:0] b [0:5];
        b = '{op, rsv, rsv, rsv, len, 8'h00};
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            cdb_valid <= 1'b1;
            cdb_byte <= b[i];
            do @(posedge clk); while (!cdb_ready);
        end
        cdb_valid <= 1'b0;
        cdb_byte <= ~b[5];
    endtask
endmodule
`default_nettype wire

// ==== dv/sir_inquiry_responder_tb_top.sv ====
// Self-checking bench for the inquiry responder with an initiator model.
// Assumes the header of shared constants is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "sir_consts.vh"
module sir_inquiry_responder_tb_top;
    logic clk, rst, abort, slow, cdb_valid, cdb_ready, dout_valid;
    logic dout_ready, cmd_done, cmd_other, rsvd_nz, busy, f, o;
    logic [7:0] cdb_byte, dout;
    logic [5:0] sent_count;
    logic [7:0] exp_t [0:48];
    logic [223:0] ids;
    int bad_count, cmp_count;
    sir_inquiry_responder u_sir_inquiry_responder (.CLK(clk), .RST(rst),
        .CDB_VALID(cdb_valid), .CDB_BYTE(cdb_byte), .CDB_READY(cdb_ready),
        .ABORT(abort), .DOUT(dout), .DOUT_VALID(dout_valid),
        .DOUT_READY(dout_ready), .CMD_DONE(cmd_done),
        .CMD_OTHER(cmd_other), .RSVD_NZ(rsvd_nz), .BUSY(busy),
        .SENT_COUNT(sent_count));
    sir_init_model u_sir_init_model (.clk(clk), .slow(slow),
        .cdb_valid(cdb_valid), .cdb_byte(cdb_byte), .cdb_ready(cdb_ready),
        .dout(dout), .dout_valid(dout_valid), .dout_ready(dout_ready));
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // Expected structure, built byte by byte; unlisted bytes stay zero.
    task automatic fill_table();
        ids = {`SIR_VEND_DEF, `SIR_PROD_DEF, `SIR_REV_DEF};
        for (int k = 0; k < 49; k++) exp_t[k] = 8'h00;
        for (int k = 0; k < 28; k++) begin
            exp_t[8 + k] = ids[223 - 8 * k -: 8];
        end
        exp_t[0] = 8'h06;
        exp_t[2] = 8'h02;
        exp_t[3] = 8'h02;
        exp_t[4] = 8'h2C;
        exp_t[39] = 8'h90;
        exp_t[41] = 8'h27;
        exp_t[42] = 8'h34;
        exp_t[43] = 8'h01;
        exp_t[44] = 8'h08;
        exp_t[45] = 8'hA0;
        exp_t[46] = 8'h08;
        exp_t[48] = 8'hFF;
    endtask
    // One command, then a bounded wait for its completion pulse.
    task automatic run(input logic [7:0] op, rsv, len);
        int n;
        u_sir_init_model.clear();
        u_sir_init_model.send_cdb(op, rsv, len);
        f = 1'b0;
        o = 1'b0;
        n = 0;
        while (f !== 1'b1 && o !== 1'b1 && n < 400) begin
            @(posedge clk);
            f = cmd_done;
            o = cmd_other;
            n++;
        end
        if (n >= 400) bad_count++;
        @(posedge clk);
        chk(8'h01, {6'h0, busy, cdb_ready});
    endtask
    task automatic chk_data(input int cnt);
        chk(cnt[7:0], u_sir_init_model.n_got[7:0]);
        for (int k = 0; k < cnt; k++) begin
            chk(exp_t[k], u_sir_init_model.got[k]);
        end
    endtask
    task automatic t_lens();
        logic [7:0] lens [0:4];
        int c;
        lens = '{8'hFF, 8'h00, 8'h01, 8'h30, 8'h31};
        for (int i = 0; i < 5; i++) begin
            slow <= i[0];
            c = (lens[i] > 8'h31) ? 49 : lens[i];
            run(8'h12, 8'h00, lens[i]);
            chk({7'h0, f}, 8'h01);
            chk({7'h0, rsvd_nz}, 8'h00);
            chk_data(c);
            chk({2'h0, sent_count}, c[7:0]);
        end
        $display("t_lens done");
    endtask
    task automatic t_other();
        logic [7:0] ops [0:3];
        ops = '{8'h00, 8'h03, 8'h13, 8'hFF};
        for (int i = 0; i < 4; i++) begin
            run(ops[i], 8'h00, 8'h10);
            chk({7'h0, o}, 8'h01);
            chk_data(0);
        end
        $display("t_other done");
    endtask
    task automatic t_rsvd();
        run(8'h12, 8'h01, 8'h06);
        chk({7'h0, rsvd_nz}, 8'h01);
        chk_data(6);
        $display("t_rsvd done");
    endtask
    // Abort mid-stream, then a short command must still work.
    task automatic t_abort();
        slow <= 1'b1;
        u_sir_init_model.send_cdb(8'h12, 8'h00, 8'h31);
        repeat (12) @(posedge clk);
        chk(8'h03, {6'h0, busy, dout_valid});
        abort <= 1'b1;
        @(posedge clk);
        abort <= 1'b0;
        #1;
        chk({6'h0, dout_valid, cdb_ready}, 8'h01);
        chk(8'h00, {7'h0, busy});
        run(8'h12, 8'h00, 8'h02);
        chk_data(2);
        $display("t_abort done");
    endtask
    // Watchdog; the whole run needs well under a tenth of this span.
    initial begin
        #300000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        abort = 1'b0;
        slow = 1'b0;
        fill_table();
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_lens();
        t_other();
        t_rsvd();
        t_abort();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== dv/sir_resp_props.sv ====
// Port-level assertions for the inquiry responder.
// Assumes one clock domain, CLK, with RST as its asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module sir_resp_props (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CDB_VALID,
    input wire logic [7:0] CDB_BYTE,
    input wire logic CDB_READY,
    input wire logic ABORT,
    input wire logic [7:0] DOUT,
    input wire logic DOUT_VALID,
    input wire logic DOUT_READY,
    input wire logic CMD_DONE,
    input wire logic CMD_OTHER,
    input wire logic RSVD_NZ,
    input wire logic BUSY,
    input wire logic [5:0] SENT_COUNT
);
    logic [2:0] idx_r;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Counts command bytes so the sixth one can be recognised.
    always @(posedge CLK or posedge RST) begin
        if (RST || ABORT) idx_r <= 3'h0;
        else if (CDB_VALID && CDB_READY)
            idx_r <= (idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1;
    end
    sequence s_take5;
        CDB_VALID && CDB_READY && idx_r == 3'h5;
    endsequence
    sequence s_eval;
        !CDB_READY ##1 (DOUT_VALID || CMD_DONE || CMD_OTHER);
    endsequence
    a_answer_start:
        assert property (disable iff (RST || ABORT) s_take5 |=> s_eval)
        else $error("no answer two cycles after the command");
    a_dout_hold:
        assert property (DOUT_VALID && !DOUT_READY && !ABORT
            |=> DOUT_VALID && $stable(DOUT)) else $error("data not held");
    a_first_type:
        assert property ($rose(DOUT_VALID) |-> DOUT == 8'h06
            && SENT_COUNT == 6'h00) else $error("first byte wrong");
    a_alen_fixed:
        assert property (DOUT_VALID && SENT_COUNT == 6'h04 |-> DOUT == 8'h2C)
        else $error("length byte wrong");
    a_end_mark:
        assert property (DOUT_VALID && SENT_COUNT == 6'h30 |-> DOUT == 8'hFF)
        else $error("end byte wrong");
    a_count_cap:
        assert property (DOUT_VALID |-> SENT_COUNT < 6'h31)
        else $error("byte beyond the structure");
    a_done_quiet:
        assert property (CMD_DONE |-> !DOUT_VALID ##1 !CMD_DONE)
        else $error("done with data or too long");
    a_other_quiet:
        assert property (CMD_OTHER |-> !DOUT_VALID && !CMD_DONE)
        else $error("other opcode answered");
    a_abort_drop:
        assert property (ABORT |=> !DOUT_VALID && CDB_READY)
        else $error("abort did not drop the command");
endmodule
bind sir_inquiry_responder sir_resp_props u_sir_resp_props (
    .CLK(CLK), .RST(RST), .CDB_VALID(CDB_VALID), .CDB_BYTE(CDB_BYTE),
    .CDB_READY(CDB_READY), .ABORT(ABORT), .DOUT(DOUT),
    .DOUT_VALID(DOUT_VALID), .DOUT_READY(DOUT_READY), .CMD_DONE(CMD_DONE),
    .CMD_OTHER(CMD_OTHER), .RSVD_NZ(RSVD_NZ), .BUSY(BUSY),
    .SENT_COUNT(SENT_COUNT));
`default_nettype wire

// ==== hw/sir_consts.vh ====
// Constants shared by the inquiry responder and its data table.
// Assumes inclusion by bare name from files under hw/.
`ifndef SIR_CONSTS_VH
`define SIR_CONSTS_VH

// Command block layout, six bytes with the opcode first.
`define SIR_OP_INQUIRY 8'h12
`define SIR_CDB_LAST 3'h5
`define SIR_CDB_OPC 3'h0
`define SIR_CDB_ALLOC 3'h4
`define SIR_CDB_RSV_LO 3'h1
`define SIR_CDB_RSV_HI 3'h3

// Structure size: a header of five bytes plus the additional length.
`define SIR_HDR_LEN 6'h05
`define SIR_ADD_LEN 8'h2C
`define SIR_STRUCT_LEN 6'h31
`define SIR_STRUCT_LEN8 8'h31

// Fixed byte values of the identification structure.
`define SIR_DEV_TYPE 8'h06
`define SIR_VERSION 8'h02
`define SIR_RESP_FMT 8'h02
`define SIR_GRP0_MARK 8'h00
`define SIR_MAP_00 8'h90
`define SIR_MAP_08 8'h00
`define SIR_MAP_10 8'h27
`define SIR_MAP_18 8'h34
`define SIR_GRP1_MARK 8'h01
`define SIR_MAP_20 8'h08
`define SIR_MAP_28 8'hA0
`define SIR_MAP_30 8'h08
`define SIR_MAP_38 8'h00
`define SIR_END_MARK 8'hFF
`define SIR_RSVD_BYTE 8'h00

// Byte positions inside the structure.
`define SIR_B_TYPE 6'h00
`define SIR_B_VER 6'h02
`define SIR_B_FMT 6'h03
`define SIR_B_ALEN 6'h04
`define SIR_B_VEND 6'h08
`define SIR_B_PROD 6'h10
`define SIR_B_REV 6'h20
`define SIR_B_G0 6'h26
`define SIR_B_G1 6'h2B
`define SIR_B_END 6'h30

// Default identification strings; the values are arbitrary.
`define SIR_VEND_DEF 64'h56454E444F522020
`define SIR_PROD_DEF 128'h464C41544245442053434E4E45522020
`define SIR_REV_DEF 32'h312E3020

`endif

// ==== hw/sir_inquiry_responder.v ====
// Inquiry command handler of a scanner target: takes a six-byte command
// block, and for the inquiry opcode streams the identification structure.
// Assumes the command bytes and the data sink run on CLK, so no input
// needs synchronising; bus phases are handled by the target controller.
//
// Operation
// - Opcode 12h in command byte 0 selects the inquiry command.
// - A zero transfer length returns no bytes and is no error.
// - Stop after the transfer length or the full structure, whichever smaller.
// - Structure is five header bytes plus 44 more, sent from byte 0 up.
// - Byte 0 carries scanner device type 06h.
// - Byte 2 version and byte 3 response format both read 02h.
// - Byte 4 holds 2Ch, never cut to the transfer length.
// - Bytes 8-15 vendor, 16-31 product, 32-35 revision, space padded ASCII.
// - Reserved fields are zero in command and in the returned bytes; a non-zero command byte 1-3 still gets an answer and only sets RSVD_NZ.
// - Byte 38 holds group marker 0 ahead of the group zero bitmap.
// - Each bitmap byte: lowest opcode at bit 7, set when supported.
// - Bitmap for opcodes 00h-07h reads 90h.
// - Byte 40, bitmap for opcodes 08h-0Fh, reads zero.
// - Bitmap for opcodes 10h-17h reads 27h.
// - Bitmap for opcodes 18h-1Fh reads 34h.
// - Byte 43 holds group marker 1 ahead of bytes 44 to 47.
// - Byte 44, bitmap for opcodes 20h-27h, reads 08h.
// - Byte 45, bitmap for opcodes 28h-2Fh, reads A0h.
// - Byte 46, bitmap for opcodes 30h-37h, reads 08h.
// - Byte 47, bitmap for opcodes 38h-3Fh, reads zero.
// - Byte 48 is the terminator FFh.
`timescale 1ns/10ps
`default_nettype none
`include "sir_consts.vh"

module sir_inquiry_responder (
    input wire CLK,
    input wire RST,
    input wire CDB_VALID,
    input wire [7:0] CDB_BYTE,
    output reg CDB_READY,
    input wire ABORT,
    output reg [7:0] DOUT,
    output reg DOUT_VALID,
    input wire DOUT_READY,
    output reg CMD_DONE,
    output reg CMD_OTHER,
    output reg RSVD_NZ,
    output reg BUSY,
    output reg [5:0] SENT_COUNT
);

    // One-hot states of the command sequencer.
    localparam [4:0] ST_CDB = 5'h01;
    localparam [4:0] ST_EVAL = 5'h02;
    localparam [4:0] ST_SEND = 5'h04;
    localparam [4:0] ST_END = 5'h08;
    localparam [4:0] ST_PASS = 5'h10;

    // Sequencer state and the captured command fields.
    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [2:0] cdb_idx_r;
    reg [2:0] cdb_idx_nxt;
    reg [7:0] opcode_r;
    reg [7:0] opcode_nxt;
    reg [7:0] alloc_r;
    reg [7:0] alloc_nxt;
    reg rsvd_r;
    reg rsvd_nxt;

    // Transfer bookkeeping.
    reg [5:0] limit_r;
    reg [5:0] limit_nxt;
    reg [5:0] idx_r;
    reg [5:0] idx_nxt;

    // Next values of the registered outputs.
    reg [7:0] dout_nxt;
    reg dout_valid_nxt;
    reg cdb_ready_nxt;
    reg cmd_done_nxt;
    reg cmd_other_nxt;
    reg rsvd_nz_nxt;
    reg busy_nxt;
    reg [5:0] sent_nxt;

    // Table lookup address and the byte it returns.
    reg [5:0] rom_addr;
    wire [7:0] rom_data;

    // Handshake terms on both sides of the block.
    wire cdb_take = CDB_VALID & CDB_READY;
    wire out_take = DOUT_VALID & DOUT_READY;

    // The structure never exceeds 49 bytes, so the smaller of the request
    // and the full size is the number of bytes this command will send.
    wire [5:0] limit_calc = (alloc_r >= `SIR_STRUCT_LEN8) ?
        `SIR_STRUCT_LEN : alloc_r[5:0];

    // A reserved command byte that is not zero; the block still answers,
    // but reports it so the controller may choose to reject the command.
    wire cdb_rsvd_hit = (cdb_idx_r >= `SIR_CDB_RSV_LO) &&
        (cdb_idx_r <= `SIR_CDB_RSV_HI) && (CDB_BYTE != 8'h00);

    // Index of the byte that follows the one now presented.
    wire [5:0] idx_inc = idx_r + 6'h01;

    // The final accepted byte of this transfer.
    wire last_out = (idx_inc == limit_r);

    // The structure table, looked up by byte number.
    sir_table u_table (
        .addr(rom_addr),
        .data(rom_data)
    );

    // Table address: byte 0 when a transfer starts, else the next byte.
    // Presenting the address from registers keeps the lookup off any
    // loop through the ready input.
    always @* begin
        rom_addr = 6'h00;
        if (state_r == ST_SEND) begin
            rom_addr = idx_inc;
        end
    end

    // Command sequencer: collect the block, decide, stream, finish.
    always @* begin
        state_nxt = state_r;
        cdb_idx_nxt = cdb_idx_r;
        opcode_nxt = opcode_r;
        alloc_nxt = alloc_r;
        rsvd_nxt = rsvd_r;
        limit_nxt = limit_r;
        idx_nxt = idx_r;
        dout_nxt = DOUT;
        dout_valid_nxt = DOUT_VALID;
        sent_nxt = SENT_COUNT;
        cmd_other_nxt = 1'b0;
        case (state_r)
            ST_CDB: begin
                // Bytes arrive in order; each field is caught by position.
                if (cdb_take) begin
                    if (cdb_idx_r == `SIR_CDB_OPC) begin
                        opcode_nxt = CDB_BYTE;
                        rsvd_nxt = 1'b0;
                    end
                    if (cdb_idx_r == `SIR_CDB_ALLOC) begin
                        alloc_nxt = CDB_BYTE;
                    end
                    if (cdb_rsvd_hit) begin
                        rsvd_nxt = 1'b1;
                    end
                    if (cdb_idx_r == `SIR_CDB_LAST) begin
                        cdb_idx_nxt = 3'h0;
                        state_nxt = ST_EVAL;
                    end else begin
                        cdb_idx_nxt = cdb_idx_r + 3'h1;
                    end
                end
            end
            ST_EVAL: begin
                // Only the inquiry opcode is served here; any other
                // command is handed back to the controller at once.
                if (opcode_r != `SIR_OP_INQUIRY) begin
                    state_nxt = ST_PASS;
                    cmd_other_nxt = 1'b1;
                end else if (alloc_r == 8'h00) begin
                    // Nothing to send, yet the command completes cleanly.
                    state_nxt = ST_END;
                    sent_nxt = 6'h00;
                end else begin
                    state_nxt = ST_SEND;
                    limit_nxt = limit_calc;
                    idx_nxt = 6'h00;
                    dout_nxt = rom_data;
                    dout_valid_nxt = 1'b1;
                    sent_nxt = 6'h00;
                end
            end
            ST_SEND: begin
                // One byte leaves per accepted handshake, in byte order.
                if (out_take) begin
                    sent_nxt = SENT_COUNT + 6'h01;
                    if (last_out) begin
                        dout_valid_nxt = 1'b0;
                        state_nxt = ST_END;
                    end else begin
                        idx_nxt = idx_inc;
                        dout_nxt = rom_data;
                    end
                end
            end
            ST_END: begin
                state_nxt = ST_CDB;
            end
            ST_PASS: begin
                state_nxt = ST_CDB;
            end
            default: begin
                state_nxt = ST_CDB;
                dout_valid_nxt = 1'b0;
            end
        endcase
        // An abort from the controller drops any command at once; the
        // partial count stays visible for the controller's status.
        if (ABORT) begin
            state_nxt = ST_CDB;
            cdb_idx_nxt = 3'h0;
            dout_valid_nxt = 1'b0;
            cmd_other_nxt = 1'b0;
        end
    end

    // Flags that follow the next state and the next reserved flag, so each output is a flip-flop.
    always @* begin
        cdb_ready_nxt = (state_nxt == ST_CDB);
        cmd_done_nxt = (state_nxt == ST_END);
        busy_nxt = (state_nxt != ST_CDB);
        rsvd_nz_nxt = rsvd_nxt;
    end

    // Sequencer registers.
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= ST_CDB;
            cdb_idx_r <= 3'h0;
            opcode_r <= 8'h00;
            alloc_r <= 8'h00;
            rsvd_r <= 1'b0;
            limit_r <= 6'h00;
            idx_r <= 6'h00;
        end else begin
            state_r <= state_nxt;
            cdb_idx_r <= cdb_idx_nxt;
            opcode_r <= opcode_nxt;
            alloc_r <= alloc_nxt;
            rsvd_r <= rsvd_nxt;
            limit_r <= limit_nxt;
            idx_r <= idx_nxt;
        end
    end

    // Output registers; ready is high from the first edge after reset.
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            CDB_READY <= 1'b0;
            DOUT <= 8'h00;
            DOUT_VALID <= 1'b0;
            CMD_DONE <= 1'b0;
            CMD_OTHER <= 1'b0;
            RSVD_NZ <= 1'b0;
            BUSY <= 1'b0;
            SENT_COUNT <= 6'h00;
        end else begin
            CDB_READY <= cdb_ready_nxt;
            DOUT <= dout_nxt;
            DOUT_VALID <= dout_valid_nxt;
            CMD_DONE <= cmd_done_nxt;
            CMD_OTHER <= cmd_other_nxt;
            RSVD_NZ <= rsvd_nz_nxt;
            BUSY <= busy_nxt;
            SENT_COUNT <= sent_nxt;
        end
    end

endmodule
`default_nettype wire

// ==== hw/sir_table.v ====
// Byte table of the 49-byte identification structure, indexed by byte.
// Assumes a registered consumer; the lookup itself is combinational.
`timescale 1ns/10ps
`default_nettype none
`include "sir_consts.vh"

module sir_table #(
    parameter [63:0] VEND_ID = `SIR_VEND_DEF,
    parameter [127:0] PROD_ID = `SIR_PROD_DEF,
    parameter [31:0] REV_ID = `SIR_REV_DEF
) (
    input wire [5:0] addr,
    output reg [7:0] data
);

    wire [5:0] vend_rel = addr - `SIR_B_VEND;
    wire [5:0] prod_rel = addr - `SIR_B_PROD;
    wire [5:0] rev_rel = addr - `SIR_B_REV;
    wire [63:0] vend_sh = VEND_ID << {vend_rel[2:0], 3'h0};
    wire [127:0] prod_sh = PROD_ID << {prod_rel[3:0], 3'h0};
    wire [31:0] rev_sh = REV_ID << {rev_rel[1:0], 3'h0};

    // Strings leave most significant byte first, so shifting left walks them.
    always @* begin
        data = `SIR_RSVD_BYTE;
        if (addr >= `SIR_B_VEND && addr < `SIR_B_PROD) begin
            data = vend_sh[63:56];
        end else if (addr >= `SIR_B_PROD && addr < `SIR_B_REV) begin
            data = prod_sh[127:120];
        end else if (addr >= `SIR_B_REV && addr < `SIR_B_REV + 6'h04) begin
            data = rev_sh[31:24];
        end else begin
            case (addr)
                `SIR_B_TYPE: data = `SIR_DEV_TYPE;
                `SIR_B_VER: data = `SIR_VERSION;
                `SIR_B_FMT: data = `SIR_RESP_FMT;
                `SIR_B_ALEN: data = `SIR_ADD_LEN;
                `SIR_B_G0: data = `SIR_GRP0_MARK;
                6'h27: data = `SIR_MAP_00;
                6'h28: data = `SIR_MAP_08;
                6'h29: data = `SIR_MAP_10;
                6'h2A: data = `SIR_MAP_18;
                `SIR_B_G1: data = `SIR_GRP1_MARK;
                6'h2C: data = `SIR_MAP_20;
                6'h2D: data = `SIR_MAP_28;
                6'h2E: data = `SIR_MAP_30;
                6'h2F: data = `SIR_MAP_38;
                `SIR_B_END: data = `SIR_END_MARK;
                default: data = `SIR_RSVD_BYTE;
            endcase
        end
    end

endmodule
`default_nettype wire
